// ---- bsp_pkg.sv ----
// Purpose: Constants and types for the boot segment code protection block
// Assumes: 10 MHz system clock, APB register access with 32-bit data
// Notes: Field layout of the two protection configuration words
//
// Behaviour
// - Boot write-protect bit 1 allows boot flash writes, 0 blocks all of them
// - A configured boot segment starts right after the vector space
// - Size code x11 defines no boot segment, top bit ignored
// - Codes 110 standard, 010 high security; 1K words less vectors, end 0007FEh
// - Codes 101 standard, 001 high security; 4K words less vectors, end 001FFEh
// - Code 000 gives high security segment ending at 003FFEh
// - Boot RAM field: 11 none, 10 128, 01 256, 00 1024 bytes
// - Secure write-protect bit 1 allows secure flash writes, 0 rejects those outside the boot segment
package bsp_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [11:0] OFS_BOOT_CFG = 12'h000;
   localparam logic [11:0] OFS_SECURE_CFG = 12'h004;
   localparam logic [11:0] OFS_BOOT_START = 12'h008;
   localparam logic [11:0] OFS_BOOT_END = 12'h00C;
   localparam logic [11:0] OFS_BOOT_RAM = 12'h010;
   localparam logic [11:0] OFS_STATUS = 12'h014;
   localparam logic [11:0] OFS_WR_CHECK = 12'h018;

   // ************************************************************
   // Field positions and reset values
   // ************************************************************
   localparam int BWP_BIT = 0;
   localparam int SIZE_LSB = 1;
   localparam int RAM_SEL_LSB = 4;
   localparam int SWP_BIT = 0;
   localparam logic [5:0] BOOT_CFG_RST = 6'h3F;
   localparam logic [0:0] SECURE_CFG_RST = 1'h1;

   // ************************************************************
   // Decode tables
   // ************************************************************
   localparam logic [23:0] VECTOR_END = 24'h000200;
   localparam logic [23:0] END_1K = 24'h0007FE;
   localparam logic [23:0] END_4K = 24'h001FFE;
   localparam logic [23:0] END_8K = 24'h003FFE;
   localparam logic [10:0] RAM_128 = 11'h080;
   localparam logic [10:0] RAM_256 = 11'h100;
   localparam logic [10:0] RAM_1024 = 11'h400;
   localparam logic [23:0] ADDR_ZERO = 24'h000000;

   typedef enum logic [1:0]
   {
      SEC_NONE = 2'h0,
      SEC_STANDARD = 2'h1,
      SEC_HIGH = 2'h2
   } security_t;

   typedef struct packed
   {
      logic present;
      security_t security;
      logic [23:0] start_addr;
      logic [23:0] end_addr;
      logic [10:0] ram_bytes;
   } boot_layout_t;

endpackage

// ---- boot_size_decode.sv ----
// Purpose: Combinational decode of boot segment size and boot RAM fields
// Assumes: Inputs come from registers on the same clock
// Notes: Pure logic, no state
`timescale 1ns/1ps
`default_nettype none
module boot_size_decode
(
   input wire logic [2:0] boot_flash_size_sel,
   input wire logic [1:0] boot_ram_size_sel,
   output var bsp_pkg::boot_layout_t layout
);

   logic [1:0] size_low;
   logic none_sel;
   assign size_low = boot_flash_size_sel[1:0];
   assign none_sel = (size_low == 2'h3);

   assign layout.present = ~none_sel;
   assign layout.security = none_sel ? bsp_pkg::SEC_NONE :
      (boot_flash_size_sel[2] ? bsp_pkg::SEC_STANDARD : bsp_pkg::SEC_HIGH);
   assign layout.start_addr = none_sel ? bsp_pkg::ADDR_ZERO : bsp_pkg::VECTOR_END;
   assign layout.end_addr = (size_low == 2'h2) ? bsp_pkg::END_1K :
      (size_low == 2'h1) ? bsp_pkg::END_4K :
      (size_low == 2'h0) ? bsp_pkg::END_8K : bsp_pkg::ADDR_ZERO;
   assign layout.ram_bytes = (boot_ram_size_sel == 2'h2) ? bsp_pkg::RAM_128 :
      (boot_ram_size_sel == 2'h1) ? bsp_pkg::RAM_256 :
      (boot_ram_size_sel == 2'h0) ? bsp_pkg::RAM_1024 : 11'h000;

endmodule
`default_nettype wire

// ---- boot_segment_code_protection.sv ----
// Purpose: APB-reachable boot and secure segment protection configuration
// Assumes: Flash programming path presents one write address at a time
// Notes: Write permission is combinational from the live configuration
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module boot_segment_code_protection
#(
   parameter int ADDR_W = 24
)
(
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [ADDR_W-1:0] FLASH_WR_ADDR,
   input wire logic FLASH_WR_REQ,
   input wire logic SECURE_HIT,
   output logic FLASH_WR_ALLOW,
   output logic FLASH_WR_BLOCKED
);

   // ************************************************************
   // Configuration registers
   // ************************************************************
   logic [5:0] boot_cfg_reg;
   logic [0:0] secure_cfg_reg;
   logic [31:0] rdata_reg;
   logic err_reg;
   logic [7:0] block_cnt_reg;
   logic [7:0] block_cnt_next;
   logic blocked_reg;

   logic access;
   logic wr_en;
   logic rd_en;
   logic hit_boot;
   logic hit_secure;
   logic hit_start;
   logic hit_end;
   logic hit_ram;
   logic hit_status;
   logic hit_check;
   logic mapped;
   logic [31:0] rdata_next;
   logic boot_write_protect;
   logic secure_write_protect;
   logic [2:0] boot_flash_size_sel;
   logic [1:0] boot_ram_size_sel;
   bsp_pkg::boot_layout_t layout;
   logic in_boot;
   logic deny;

   assign access = PSEL & PENABLE;
   assign wr_en = access & PWRITE;
   // Read data is captured in the setup cycle, ahead of the access phase
   assign rd_en = PSEL & ~PENABLE & ~PWRITE;
   assign hit_boot = (PADDR == bsp_pkg::OFS_BOOT_CFG);
   assign hit_secure = (PADDR == bsp_pkg::OFS_SECURE_CFG);
   assign hit_start = (PADDR == bsp_pkg::OFS_BOOT_START);
   assign hit_end = (PADDR == bsp_pkg::OFS_BOOT_END);
   assign hit_ram = (PADDR == bsp_pkg::OFS_BOOT_RAM);
   assign hit_status = (PADDR == bsp_pkg::OFS_STATUS);
   assign hit_check = (PADDR == bsp_pkg::OFS_WR_CHECK);
   assign mapped = hit_boot | hit_secure | hit_start | hit_end | hit_ram | hit_status
      | hit_check;

   assign boot_write_protect = boot_cfg_reg[bsp_pkg::BWP_BIT];
   assign boot_flash_size_sel = boot_cfg_reg[bsp_pkg::SIZE_LSB +: 3];
   assign boot_ram_size_sel = boot_cfg_reg[bsp_pkg::RAM_SEL_LSB +: 2];
   assign secure_write_protect = secure_cfg_reg[bsp_pkg::SWP_BIT];

   boot_size_decode u_decode
   (
      .boot_flash_size_sel(boot_flash_size_sel),
      .boot_ram_size_sel(boot_ram_size_sel),
      .layout(layout)
   );

   // ************************************************************
   // Write permission
   // ************************************************************
   // Decoded straight from the live registers so a new setting bites at once
   assign in_boot = layout.present && (FLASH_WR_ADDR >= layout.start_addr)
      && (FLASH_WR_ADDR <= layout.end_addr);
   assign deny = (in_boot & ~boot_write_protect)
      | (SECURE_HIT & ~in_boot & ~secure_write_protect);
   assign FLASH_WR_ALLOW = FLASH_WR_REQ & ~deny;
   assign block_cnt_next = (FLASH_WR_REQ & deny & (block_cnt_reg != 8'hFF))
      ? block_cnt_reg + 8'h01 : block_cnt_reg;

   assign rdata_next = hit_boot ? {26'h0000000, boot_cfg_reg} :
      hit_secure ? {31'h00000000, secure_cfg_reg} :
      hit_start ? {8'h00, layout.start_addr} :
      hit_end ? {8'h00, layout.end_addr} :
      hit_ram ? {21'h000000, layout.ram_bytes} :
      hit_status ? {21'h000000, block_cnt_reg, layout.present, layout.security} :
      hit_check ? {30'h00000000, deny, in_boot} : 32'h00000000;

   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
      begin
         boot_cfg_reg <= bsp_pkg::BOOT_CFG_RST;
         secure_cfg_reg <= bsp_pkg::SECURE_CFG_RST;
      end
      else if (wr_en & hit_boot)
         boot_cfg_reg <= PWDATA[5:0];
      else if (wr_en & hit_secure)
         secure_cfg_reg <= PWDATA[0:0];
   end

   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
      begin
         rdata_reg <= 32'h00000000;
         err_reg <= 1'b0;
         block_cnt_reg <= 8'h00;
         blocked_reg <= 1'b0;
      end
      else
      begin
         rdata_reg <= rd_en ? rdata_next : rdata_reg;
         err_reg <= PSEL & ~PENABLE & ~mapped;
         block_cnt_reg <= block_cnt_next;
         blocked_reg <= FLASH_WR_REQ & deny;
      end
   end

   // Data is latched in the setup cycle so the access phase ends in one cycle
   assign PREADY = 1'b1;
   assign PRDATA = rdata_reg;
   assign PSLVERR = access & err_reg;
   assign FLASH_WR_BLOCKED = blocked_reg;

   // ************************************************************
   // Checks
   // ************************************************************
   sequence s_cfg_write(logic [11:0] ofs);
      PSEL && PENABLE && PWRITE && PADDR == ofs;
   endsequence

   sequence s_denied_req;
      FLASH_WR_REQ && deny;
   endsequence

   a_boot_wp_block: assert property (@(posedge CLK_SYS) disable iff (RST)
      (FLASH_WR_REQ && in_boot && !boot_write_protect) |-> !FLASH_WR_ALLOW)
      else $error("boot segment write not blocked");
   a_boot_wp_allow: assert property (@(posedge CLK_SYS) disable iff (RST)
      (FLASH_WR_REQ && in_boot && boot_write_protect) |-> FLASH_WR_ALLOW)
      else $error("boot segment write wrongly blocked");
   a_boot_start: assert property (@(posedge CLK_SYS) disable iff (RST)
      layout.present |-> layout.start_addr == bsp_pkg::VECTOR_END)
      else $error("boot start not after vectors");
   a_none_code: assert property (@(posedge CLK_SYS) disable iff (RST)
      (boot_flash_size_sel[1:0] == 2'h3) |-> !layout.present && !in_boot)
      else $error("x11 still defines a segment");
   a_size_1k: assert property (@(posedge CLK_SYS) disable iff (RST)
      (boot_flash_size_sel[1:0] == 2'h2) |-> layout.end_addr == 24'h0007FE
      && layout.security == (boot_flash_size_sel[2] ? bsp_pkg::SEC_STANDARD
      : bsp_pkg::SEC_HIGH))
      else $error("1K segment decode wrong");
   a_size_4k: assert property (@(posedge CLK_SYS) disable iff (RST)
      (boot_flash_size_sel[1:0] == 2'h1) |-> layout.end_addr == 24'h001FFE)
      else $error("4K segment end wrong");
   a_size_hi: assert property (@(posedge CLK_SYS) disable iff (RST)
      (boot_flash_size_sel == 3'h0) |-> layout.end_addr == 24'h003FFE
      && layout.security == bsp_pkg::SEC_HIGH)
      else $error("code 000 decode wrong");
   a_size_std: assert property (@(posedge CLK_SYS) disable iff (RST)
      (boot_flash_size_sel == 3'h4) |-> layout.end_addr == 24'h003FFE
      && layout.security == bsp_pkg::SEC_STANDARD)
      else $error("code 100 decode wrong");
   a_ram_size: assert property (@(posedge CLK_SYS) disable iff (RST)
      (boot_ram_size_sel == 2'h0) |-> layout.ram_bytes == 11'h400)
      else $error("1024 byte boot ram decode wrong");
   a_secure_wp: assert property (@(posedge CLK_SYS) disable iff (RST)
      (FLASH_WR_REQ && SECURE_HIT && !in_boot && !secure_write_protect) |->
      !FLASH_WR_ALLOW ##1 FLASH_WR_BLOCKED)
      else $error("secure segment write not rejected");
   a_secure_immediate: assert property (@(posedge CLK_SYS) disable iff (RST)
      s_cfg_write(bsp_pkg::OFS_SECURE_CFG) ##1 1'b1 |->
      secure_write_protect == $past(PWDATA[0]))
      else $error("secure protect change not immediate");
   a_boot_immediate: assert property (@(posedge CLK_SYS) disable iff (RST)
      s_cfg_write(bsp_pkg::OFS_BOOT_CFG) ##1 1'b1 |->
      boot_write_protect == $past(PWDATA[0]))
      else $error("boot protect change not immediate");
   a_blocked_flag: assert property (@(posedge CLK_SYS) disable iff (RST)
      s_denied_req |=> FLASH_WR_BLOCKED)
      else $error("denied write not flagged");
   a_none_allow: assert property (@(posedge CLK_SYS) disable iff (RST)
      (boot_flash_size_sel[1:0] == 2'h3 && FLASH_WR_REQ && !SECURE_HIT) |-> FLASH_WR_ALLOW)
      else $error("write blocked with no boot segment");
   a_below_start: assert property (@(posedge CLK_SYS) disable iff (RST)
      (FLASH_WR_ADDR < bsp_pkg::VECTOR_END) |-> !in_boot)
      else $error("vector space counted as boot segment");
   a_size_4k_sec: assert property (@(posedge CLK_SYS) disable iff (RST)
      (boot_flash_size_sel[1:0] == 2'h1) |-> layout.security ==
      (boot_flash_size_sel[2] ? bsp_pkg::SEC_STANDARD : bsp_pkg::SEC_HIGH))
      else $error("4K segment security wrong");
   a_ram_128: assert property (@(posedge CLK_SYS) disable iff (RST)
      (boot_ram_size_sel == 2'h2) |-> layout.ram_bytes == 11'h080)
      else $error("128 byte boot ram decode wrong");
   a_ram_256: assert property (@(posedge CLK_SYS) disable iff (RST)
      (boot_ram_size_sel == 2'h1) |-> layout.ram_bytes == 11'h100)
      else $error("256 byte boot ram decode wrong");
   a_ram_none: assert property (@(posedge CLK_SYS) disable iff (RST)
      (boot_ram_size_sel == 2'h3) |-> layout.ram_bytes == 11'h000)
      else $error("absent boot ram decode wrong");
   a_secure_allow: assert property (@(posedge CLK_SYS) disable iff (RST)
      (FLASH_WR_REQ && SECURE_HIT && !in_boot && secure_write_protect) |-> FLASH_WR_ALLOW)
      else $error("secure segment write wrongly rejected");

endmodule
`default_nettype wire

// ---- test_boot_segment_code_protection.sv ----
// Purpose: Self-checking bench for the boot segment code protection block
// Assumes: APB slave answers with PREADY, flash check outputs settle within a cycle
// Notes: Register expectations come from the size and boot RAM decode tables
`timescale 1ns/1ps
`default_nettype none
module test_boot_segment_code_protection;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [23:0] wr_addr = 24'h000000;
   logic wr_req = 1'b0;
   logic secure_hit = 1'b0;
   logic wr_allow;
   logic wr_blocked;
   int n_errors = 0;
   int checked = 0;
   logic [31:0] rd;
   logic err;
   logic [31:0] exp_end;

   always #50 clk_sys = ~clk_sys;

   boot_segment_code_protection u_dut
   (
      .CLK_SYS(clk_sys), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .FLASH_WR_ADDR(wr_addr), .FLASH_WR_REQ(wr_req), .SECURE_HIT(secure_hit),
      .FLASH_WR_ALLOW(wr_allow), .FLASH_WR_BLOCKED(wr_blocked)
   );

   // ************************************************************
   // Access and compare tasks
   // ************************************************************
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   // Holds the request until PREADY is seen high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      // Only the watchdog ends a wait that never sees PREADY
      do
      begin
         @(posedge clk_sys);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      check(what, exp, rd);
   endtask

   // A request stands for one cycle; blocked flag follows one cycle later
   task automatic flash(input logic [23:0] a, input logic hit, input logic al, input logic bl);
      @(posedge clk_sys);
      wr_req <= 1'b1;
      wr_addr <= a;
      secure_hit <= hit;
      @(negedge clk_sys);
      check("allow", {31'h0, al}, {31'h0, wr_allow});
      @(posedge clk_sys);
      wr_req <= 1'b0;
      @(negedge clk_sys);
      check("blocked", {31'h0, bl}, {31'h0, wr_blocked});
   endtask

   task automatic end_sim;
      $display("comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      #1000000;
      n_errors++;
      end_sim;
   end

   // ************************************************************
   // Test sequence
   // ************************************************************
   initial
   begin
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      rdchk("boot cfg", bsp_pkg::OFS_BOOT_CFG, 32'h0000003F);
      rdchk("secure cfg", bsp_pkg::OFS_SECURE_CFG, 32'h00000001);
      rdchk("start none", bsp_pkg::OFS_BOOT_START, 32'h00000000);
      rdchk("ram none", bsp_pkg::OFS_BOOT_RAM, 32'h00000000);
      $display("test reset values done");
      for (int c = 0; c < 8; c++)
      begin
         apb(1'b1, bsp_pkg::OFS_BOOT_CFG, {26'h0, 2'b11, c[2:0], 1'b0});
         case (c[1:0])
            2'b10: exp_end = {8'h0, bsp_pkg::END_1K};
            2'b01: exp_end = {8'h0, bsp_pkg::END_4K};
            2'b00: exp_end = {8'h0, bsp_pkg::END_8K};
            default: exp_end = 32'h00000000;
         endcase
         rdchk("end", bsp_pkg::OFS_BOOT_END, exp_end);
         rdchk("start", bsp_pkg::OFS_BOOT_START,
            (c[1:0] == 2'b11) ? 32'h00000000 : {8'h0, bsp_pkg::VECTOR_END});
         apb(1'b0, bsp_pkg::OFS_STATUS, 32'h00000000);
         check("security", (c[1:0] == 2'b11) ? 32'h00000000 :
            (c[2] ? 32'h00000005 : 32'h00000006), rd & 32'h00000007);
      end
      $display("test size codes done");
      for (int r = 0; r < 4; r++)
      begin
         apb(1'b1, bsp_pkg::OFS_BOOT_CFG, {26'h0, r[1:0], 3'b110, 1'b1});
         rdchk("ram", bsp_pkg::OFS_BOOT_RAM, (r == 0) ? {21'h0, bsp_pkg::RAM_1024} :
            (r == 1) ? {21'h0, bsp_pkg::RAM_256} :
            (r == 2) ? {21'h0, bsp_pkg::RAM_128} : 32'h00000000);
      end
      $display("test boot ram done");
      apb(1'b1, bsp_pkg::OFS_BOOT_CFG, 32'h0000003C);
      flash(24'h000300, 1'b0, 1'b0, 1'b1);
      rdchk("check in boot", bsp_pkg::OFS_WR_CHECK, 32'h00000003);
      flash(24'h000100, 1'b0, 1'b1, 1'b0);
      apb(1'b1, bsp_pkg::OFS_BOOT_CFG, 32'h0000003D);
      flash(24'h000300, 1'b0, 1'b1, 1'b0);
      apb(1'b1, bsp_pkg::OFS_SECURE_CFG, 32'h00000000);
      flash(24'h001000, 1'b1, 1'b0, 1'b1);
      rdchk("check secure", bsp_pkg::OFS_WR_CHECK, 32'h00000002);
      apb(1'b1, bsp_pkg::OFS_SECURE_CFG, 32'h00000001);
      flash(24'h001000, 1'b1, 1'b1, 1'b0);
      apb(1'b0, bsp_pkg::OFS_STATUS, 32'h00000000);
      check("blocked count", 32'h00000002, (rd >> 3) & 32'h000000FF);
      check("mapped err", 32'h00000000, {31'h0, err});
      $display("test write protection done");
      apb(1'b0, 12'h0FC, 32'h00000000);
      check("unmapped err", 32'h00000001, {31'h0, err});
      check("unmapped data", 32'h00000000, rd);
      $display("test unmapped access done");
      end_sim;
   end
endmodule
`default_nettype wire
